// >>> beat_buffer2.sv
// Two-entry buffer between the buffer memory and the array programming port
`timescale 1ns/1ps
module beat_buffer2
  import spi_flash_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          rstn_i,
  input  wire logic          flush_i,
  input  wire logic          in_valid_i,
  input  wire prog_beat_type in_beat_i,
  output logic               in_ready_o,
  output logic               out_valid_o,
  output prog_beat_type      out_beat_o,
  input  wire logic          out_ready_i
);

  buf_state_type r;
  buf_state_type next_r;
  logic          push;
  logic          pop;
  logic [1:0]    slot;

  assign in_ready_o  = (r.cnt != 2'h2);
  assign out_valid_o = (r.cnt != 2'h0);
  assign out_beat_o  = r.ent0;

  always_comb begin
    next_r = r;
    push   = in_valid_i & in_ready_o;
    pop    = out_valid_o & out_ready_i;
    slot   = r.cnt - {1'b0, pop};
    if (pop) begin
      next_r.ent0 = r.ent1;
    end
    if (push) begin
      if (slot == 2'h0) begin
        next_r.ent0 = in_beat_i;
      end else begin
        next_r.ent1 = in_beat_i;
      end
    end
    next_r.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    if (!rstn_i || flush_i) begin
      next_r.cnt = 2'h0;
    end
    if (!rstn_i) begin
      next_r = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    r <= next_r;
  end

endmodule

// >>> pin_sync.sv
// Two-stage synchroniser for the serial link pins
`timescale 1ns/1ps
module pin_sync
  import spi_flash_pkg::*;
(
  input  wire logic           sys_clk_i,
  input  wire logic           rstn_i,
  input  wire pin_bundle_type pins_i,
  output pin_bundle_type      pins_o
);

  sync_state_type r;
  sync_state_type next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = pins_i;
    next_r.s2 = r.s1;
    if (!rstn_i) begin
      next_r = '0;
      next_r.s1.cs_n = 1'b1;
      next_r.s2.cs_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    r <= next_r;
  end

  assign pins_o = r.s2;

endmodule

// >>> spi_flash_buffer_and_wrap.sv
// Serial flash command logic: burst wrap setting, page buffer access, buffer to page program
`timescale 1ns/1ps
`include "spi_flash_map.svh"
module spi_flash_buffer_and_wrap
  import spi_flash_pkg::*;
#(
  parameter int unsigned TPP_US = `TPP_US_DEFAULT
)(
  input  wire logic          sys_clk_i,
  input  wire logic          rstn_i,
  input  wire logic          sck_i,
  input  wire logic          cs_n_i,
  input  wire logic [3:0]    io_i,
  output logic               so_o,
  output logic               so_oe_o,
  input  wire logic          write_enable_latch_i,
  output logic               wel_clear_o,
  output logic               busy_flag_o,
  output logic               prog_valid_o,
  output prog_beat_type      prog_beat_o,
  output logic [15:0]        prog_page_o,
  input  wire logic          prog_ready_i,
  input  wire logic [23:0]   qread_addr_i,
  output logic [23:0]        rd_next_addr_o,
  output logic               wrap_enable_o,
  output logic [1:0]         wrap_len_sel_o
);

  localparam int unsigned TPP_CYC = TPP_US * `SYS_CLK_MHZ;

  ctl_state_type  r;
  ctl_state_type  next_r;
  pin_bundle_type pins_raw;
  pin_bundle_type pins;
  logic [7:0]     mem [0:255];
  logic           mem_we;
  logic [7:0]     mem_wa;
  logic [7:0]     mem_wd;
  logic           sck_rise;
  logic           sck_fall;
  logic           cs_rise;
  logic [7:0]     shin_n;
  logic [7:0]     rd_byte;
  logic           prog_ok;
  logic           timeout;
  logic           beat_valid;
  prog_beat_type  beat_in;
  logic           beat_ready;
  logic           fifo_flush;
  logic [5:0]     wrap_mask;
  logic [23:0]    addr_inc;

  assign pins_raw = '{sck: sck_i, cs_n: cs_n_i, io: io_i};

  pin_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pins_i    (pins_raw),
    .pins_o    (pins)
  );

  beat_buffer2 u_beats (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .flush_i     (fifo_flush),
    .in_valid_i  (beat_valid),
    .in_beat_i   (beat_in),
    .in_ready_o  (beat_ready),
    .out_valid_o (prog_valid_o),
    .out_beat_o  (prog_beat_o),
    .out_ready_i (prog_ready_i)
  );

  assign sck_rise = pins.sck & ~r.sck_q & ~pins.cs_n;
  assign sck_fall = ~pins.sck & r.sck_q & ~pins.cs_n;
  assign cs_rise  = pins.cs_n & ~r.cs_q;
  assign shin_n   = {r.shin[6:0], pins.io[0]};
  assign rd_byte  = mem[r.bptr];
  assign timeout  = (r.ptime == 24'(TPP_CYC - 1));
  assign prog_ok  = (r.cnt >= `ADDR_END) && (r.bitc == 3'h0)
                    && write_enable_latch_i && !r.busy;

  // Program engine reads the buffer in offset order into the two-entry buffer
  assign beat_valid = r.busy & ~r.pidx[8];
  assign beat_in    = '{offset: r.pidx[7:0], data: mem[r.pidx[7:0]]};

  always_comb begin
    case (r.wrap_cfg[2:1])
      2'h0:    wrap_mask = 6'h07;
      2'h1:    wrap_mask = 6'h0F;
      2'h2:    wrap_mask = 6'h1F;
      default: wrap_mask = 6'h3F;
    endcase
    addr_inc = qread_addr_i + 24'h00_0001;
  end

  always_comb begin
    next_r         = r;
    mem_we         = 1'b0;
    mem_wa         = r.bptr;
    mem_wd         = shin_n;
    fifo_flush     = 1'b0;
    next_r.wel_clr = 1'b0;
    next_r.sck_q   = pins.sck;
    next_r.cs_q    = pins.cs_n;

    // Wrapped reads stay inside the aligned section; linear otherwise
    if (!r.wrap_cfg[0]) begin
      next_r.next_addr = (qread_addr_i & ~{18'h0_0000, wrap_mask})
                         | (addr_inc & {18'h0_0000, wrap_mask});
    end else begin
      next_r.next_addr = addr_inc;
    end

    if (pins.cs_n) begin
      if (cs_rise) begin
        case (r.st)
          S_WRAP: begin
            if ((r.cnt >= `WRAP_END) && (r.bitc == 3'h0)) begin
              next_r.wrap_cfg = r.wrap_sh[`WRAP_SEL_HI:`WRAP_SEL_LO];
            end
          end
          S_PROG: begin
            if (r.cnt < `ADDR_END) begin
              next_r.wel_clr = 1'b1;
            end else if (prog_ok) begin
              next_r.busy    = 1'b1;
              next_r.pidx    = 9'h000;
              next_r.ptime   = 24'h00_0000;
              next_r.page    = r.addr[23:8];
              next_r.wel_clr = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      // Deselect ends any frame; a partial write byte is simply dropped
      next_r.st    = S_CMD;
      next_r.cnt   = 6'h00;
      next_r.bitc  = 3'h0;
      next_r.so_oe = 1'b0;
    end else if (sck_rise) begin
      next_r.shin = shin_n;
      next_r.bitc = r.bitc + 3'h1;
      next_r.cnt  = (r.cnt == `CNT_MAX) ? r.cnt : r.cnt + 6'h01;
      next_r.addr = {r.addr[22:0], pins.io[0]};
      case (r.st)
        S_CMD: begin
          if (r.bitc == 3'h7) begin
            case (shin_n)
              `OPC_SET_WRAP:  next_r.st = S_WRAP;
              `OPC_BUF_READ:  next_r.st = S_BREAD;
              `OPC_BUF_WRITE: next_r.st = (write_enable_latch_i && !r.busy) ? S_BWRITE : S_SKIP;
              `OPC_BUF_PROG:  next_r.st = r.busy ? S_SKIP : S_PROG;
              default:        next_r.st = S_SKIP;
            endcase
          end
        end
        S_WRAP: begin
          // Address nibbles are counted only; the wrap byte comes on all four lines
          if ((r.cnt >= `WRAP_ADDR_END) && (r.cnt < `WRAP_END)) begin
            next_r.wrap_sh = {r.wrap_sh[3:0], pins.io};
          end
        end
        S_BREAD: begin
          if (r.cnt == `ADDR_END - 6'h01) begin
            next_r.bptr = shin_n;
          end
        end
        S_BWRITE: begin
          if (r.cnt == `ADDR_END - 6'h01) begin
            next_r.bptr = shin_n;
          end else if ((r.cnt >= `ADDR_END) && (r.bitc == 3'h7)) begin
            mem_we      = 1'b1;
            next_r.bptr = r.bptr + 8'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (sck_fall && (r.st == S_BREAD) && (r.cnt >= `RD_DATA_START)) begin
      if (r.bitc == 3'h0) begin
        next_r.so     = rd_byte[7];
        next_r.out_sh = rd_byte[6:0];
        next_r.bptr   = r.bptr + 8'h01;
        next_r.so_oe  = 1'b1;
      end else begin
        next_r.so     = r.out_sh[6];
        next_r.out_sh = {r.out_sh[5:0], 1'b0};
      end
    end

    if (r.busy) begin
      next_r.ptime = r.ptime + 24'h00_0001;
      if (beat_valid && beat_ready) begin
        next_r.pidx = r.pidx + 9'h001;
      end
      if ((r.pidx[8] && !prog_valid_o) || timeout) begin
        next_r.busy = 1'b0;
        fifo_flush  = timeout;
      end
    end

    if (!rstn_i) begin
      next_r          = '0;
      next_r.st       = S_CMD;
      next_r.cs_q     = 1'b1;
      next_r.wrap_cfg = `WRAP_RST;
      mem_we          = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    r <= next_r;
  end

  always_ff @(posedge sys_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign so_o           = r.so;
  assign so_oe_o        = r.so_oe;
  assign wel_clear_o    = r.wel_clr;
  assign busy_flag_o    = r.busy;
  assign prog_page_o    = r.page;
  assign rd_next_addr_o = r.next_addr;
  assign wrap_enable_o  = ~r.wrap_cfg[0];
  assign wrap_len_sel_o = r.wrap_cfg[2:1];

  property p_wrap_reset;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !$past(rstn_i) |-> (r.wrap_cfg == `WRAP_RST);
  endproperty
  a_wrap_reset: assert property (p_wrap_reset)
    else $error("wrap setting not disabled after reset");

  property p_wrap_keep;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $changed(r.wrap_cfg) |->
        $past(cs_rise && (r.st == S_WRAP) && (r.cnt >= `WRAP_END) && (r.bitc == 3'h0));
  endproperty
  a_wrap_keep: assert property (p_wrap_keep)
    else $error("wrap setting changed without a complete wrap command");

  property p_wrap_take;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (cs_rise && (r.st == S_WRAP) && (r.cnt >= `WRAP_END) && (r.bitc == 3'h0))
        |=> (r.wrap_cfg == $past(r.wrap_sh[6:4])) && (wrap_enable_o == !$past(r.wrap_sh[4]));
  endproperty
  a_wrap_take: assert property (p_wrap_take)
    else $error("wrap byte not stored from bits 6 to 4");

  property p_wrap_addr;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (!r.wrap_cfg[0] && (r.wrap_cfg[2:1] == 2'h0) && (qread_addr_i[2:0] == 3'h7))
        |=> (rd_next_addr_o == {$past(qread_addr_i[23:3]), 3'h0});
  endproperty
  a_wrap_addr: assert property (p_wrap_addr)
    else $error("eight byte wrap did not return to section start");

  property p_linear_addr;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      r.wrap_cfg[0] |=> (rd_next_addr_o == $past(qread_addr_i) + 24'h00_0001);
  endproperty
  a_linear_addr: assert property (p_linear_addr)
    else $error("linear read address not incremented");

  property p_so_float;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      cs_rise |=> !so_oe_o;
  endproperty
  a_so_float: assert property (p_so_float)
    else $error("serial output still driven after deselect");

  property p_so_phase;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      so_oe_o |-> (r.st == S_BREAD) && (r.cnt >= `RD_DATA_START) && !r.cs_q;
  endproperty
  a_so_phase: assert property (p_so_phase)
    else $error("serial output driven outside buffer read data");

  property p_write_step;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      mem_we |=> (r.bptr == $past(r.bptr) + 8'h01) && (r.st == S_BWRITE);
  endproperty
  a_write_step: assert property (p_write_step)
    else $error("buffer write pointer did not advance");

  property p_prog_start;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (cs_rise && (r.st == S_PROG) && prog_ok)
        |=> busy_flag_o && wel_clear_o && (prog_page_o == $past(r.addr[23:8]));
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("page program did not start at deselect");

  property p_prog_end;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $fell(busy_flag_o) |-> $past(r.pidx[8] || timeout);
  endproperty
  a_prog_end: assert property (p_prog_end)
    else $error("program ended before all buffer bytes moved");

  property p_prog_time;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      busy_flag_o |-> (r.ptime < 24'(TPP_CYC));
  endproperty
  a_prog_time: assert property (p_prog_time)
    else $error("page program exceeded its time limit");

endmodule

// >>> spi_flash_map.svh
// Opcodes, phase boundaries, reset values and timing figures of the flash buffer block
`ifndef SPI_FLASH_MAP_SVH
`define SPI_FLASH_MAP_SVH

`define OPC_SET_WRAP       8'h77
`define OPC_BUF_READ       8'hD4
`define OPC_BUF_WRITE      8'h84
`define OPC_BUF_PROG       8'h88

// Serial clock counts from the start of a frame
`define ADDR_END           6'h20
`define RD_DATA_START      6'h28
`define WRAP_ADDR_END      6'h0E
`define WRAP_END           6'h10
`define CNT_MAX            6'h3F

// Stored wrap setting is {W6,W5,W4}; W4 high means linear reads
`define WRAP_RST           3'h1
`define WRAP_SEL_HI        6
`define WRAP_SEL_LO        4

`define SYS_CLK_MHZ        50
// Page program limit in microseconds (plain default)
`define TPP_US_DEFAULT     3000

`endif

// >>> spi_flash_pkg.sv
// Types shared by the flash buffer and wrap logic
package spi_flash_pkg;

  typedef enum logic [5:0] {
    S_CMD    = 6'h01,
    S_WRAP   = 6'h02,
    S_BREAD  = 6'h04,
    S_BWRITE = 6'h08,
    S_PROG   = 6'h10,
    S_SKIP   = 6'h20
  } link_state_type;

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic [3:0] io;
  } pin_bundle_type;

  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] data;
  } prog_beat_type;

  typedef struct packed {
    pin_bundle_type s1;
    pin_bundle_type s2;
  } sync_state_type;

  typedef struct packed {
    prog_beat_type ent0;
    prog_beat_type ent1;
    logic [1:0]    cnt;
  } buf_state_type;

  typedef struct packed {
    link_state_type st;
    logic [7:0]     shin;
    logic [5:0]     cnt;
    logic [2:0]     bitc;
    logic [23:0]    addr;
    logic [7:0]     wrap_sh;
    logic [2:0]     wrap_cfg;
    logic [7:0]     bptr;
    logic [6:0]     out_sh;
    logic           so;
    logic           so_oe;
    logic           sck_q;
    logic           cs_q;
    logic           busy;
    logic [15:0]    page;
    logic [8:0]     pidx;
    logic [23:0]    ptime;
    logic           wel_clr;
    logic [23:0]    next_addr;
  } ctl_state_type;

endpackage

// >>> spi_host_model.sv
// Host side of the serial link: chip select, serial clock and data pins
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic  sys_clk_i,
  input  wire logic  so_i,
  input  wire logic  so_oe_i,
  output logic       sck_o,
  output logic       cs_n_o,
  output logic [3:0] io_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h5;
  end

  // Half a link period is four system clocks, driven just after the edge
  task automatic half();
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask

  // Serial clock stands low between frames
  task automatic sel(input logic on);
    half();
    cs_n_o = !on;
    if (!on) begin
      io_o = ~io_o;
    end
  endtask

  // Data set while the clock is low, read data taken at the rising edge
  task automatic tick(input logic [3:0] v, output logic s);
    io_o = v;
    half();
    sck_o = 1'b1;
    // A released output line reads as the inverse of its last value
    s = so_oe_i ? so_i : ~so_i;
    half();
    sck_o = 1'b0;
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the flash buffer and wrap block
`timescale 1ns/1ps
module tb_top;
  import spi_flash_pkg::*;
  logic          sys_clk_i = 1'b0;
  logic          rstn_i = 1'b0;
  logic          sck, cs_n, so, so_oe, write_enable_latch, wel_clr, busy, pvalid, pready, wrap_en, s, c;
  logic [3:0]    io;
  prog_beat_type beat;
  logic [15:0]   page, pg_exp;
  logic [23:0]   qaddr, nxt;
  logic [1:0]    wsel;
  logic [7:0]    w;
  logic [31:0]   seed = 32'h0000_f247;
  logic [2:0]    wcfg = 3'h1;
  int            err_total = 0;
  int            checks = 0;
  int            beats, clears;
  int            mem [256];

  spi_flash_buffer_and_wrap #(.TPP_US(20)) u_dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(io),
    .so_o(so), .so_oe_o(so_oe), .write_enable_latch_i(write_enable_latch), .wel_clear_o(wel_clr),
    .busy_flag_o(busy), .prog_valid_o(pvalid), .prog_beat_o(beat), .prog_page_o(page),
    .prog_ready_i(pready), .qread_addr_i(qaddr), .rd_next_addr_o(nxt),
    .wrap_enable_o(wrap_en), .wrap_len_sel_o(wsel));
  spi_host_model u_host (.sys_clk_i(sys_clk_i), .so_i(so), .so_oe_i(so_oe), .sck_o(sck),
    .cs_n_o(cs_n), .io_o(io));

  always #10 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [23:0] next_exp(input logic [23:0] a);
    logic [23:0] m;
    m = (24'h00_0008 << wcfg[2:1]) - 24'h00_0001;
    return wcfg[0] ? a + 24'h00_0001 : (a & ~m) | ((a + 24'h00_0001) & m);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Array side stalls at random; the write enable latch is cleared on request
  always @(posedge sys_clk_i) begin
    c = (wel_clr === 1'b1);
    if (pvalid === 1'b1 && pready === 1'b1) begin
      chk(beat.offset, beats);
      chk(beat.data, mem[beats[7:0]]);
      chk(page, pg_exp);
      beats++;
    end
    if (c) clears++;
    #1;
    if (c) write_enable_latch = 1'b0;
    pready = (rnd() % 4) != 0;
    qaddr = 24'(rnd());
  end

  task automatic chk_wrap();
    logic [23:0] a;
    repeat (8) @(posedge sys_clk_i);
    chk(wrap_en, !wcfg[0]);
    chk(wsel, wcfg[2:1]);
    repeat (4) begin
      @(posedge sys_clk_i);
      a = qaddr;
      #1;
      chk(nxt, next_exp(a));
    end
  endtask

  task automatic xbyte(input logic [7:0] b, input int n, output logic [7:0] r);
    for (int i = 7; i > 7 - n; i--) begin
      u_host.tick({{3{~b[i]}}, b[i]}, s);
      r = {r[6:0], s};
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] r;
    u_host.sel(1'b1);
    xbyte(op, 8, r);
    for (int i = 2; i >= 0; i--) xbyte(a[8*i +: 8], 8, r);
  endtask

  task automatic set_wrap(input logic [7:0] wb, input int clocks);
    logic [7:0] r;
    u_host.sel(1'b1);
    xbyte(8'h77, 8, r);
    for (int i = 0; i < clocks - 8; i++) begin
      u_host.tick(i == 6 ? wb[7:4] : i == 7 ? wb[3:0] : 4'(rnd()), s);
    end
    u_host.sel(1'b0);
    if (clocks % 8 == 0) wcfg = wb[6:4];
  endtask

  task automatic bwrite(input logic [7:0] start, input int n, input int bits);
    logic [7:0] r, d;
    cmd(8'h84, {16'(rnd()), start});
    for (int k = 0; k < n; k++) begin
      d = 8'(rnd());
      xbyte(d, 8, r);
      if (write_enable_latch) mem[8'(start + k)] = d;
    end
    if (bits > 0) xbyte(8'(rnd()), bits, r);
    u_host.sel(1'b0);
  endtask

  task automatic bread(input logic [7:0] start, input int n);
    logic [7:0] r;
    cmd(8'hD4, {16'(rnd()), start});
    xbyte(8'(rnd()), 8, r);
    for (int k = 0; k < n; k++) begin
      xbyte(8'(rnd()), 8, r);
      chk(r, mem[8'(start + k)]);
    end
    xbyte(8'h00, 3, r);
    chk(so_oe, 1);
    u_host.sel(1'b0);
    repeat (8) @(posedge sys_clk_i);
    #1;
    chk(so_oe, 0);
  endtask

  task automatic bprog(input logic [23:0] a, input logic en, input int nb);
    logic [7:0] r;
    write_enable_latch = en;
    beats = 0;
    clears = 0;
    pg_exp = a[23:8];
    u_host.sel(1'b1);
    xbyte(8'h88, 8, r);
    for (int i = 2; i > 2 - nb; i--) xbyte(a[8*i +: 8], 8, r);
    u_host.sel(1'b0);
    repeat (8) @(posedge sys_clk_i);
    chk(busy, en && nb == 3);
    for (int i = 0; i < 1100 && busy === 1'b1; i++) @(posedge sys_clk_i);
    #1;
    chk(busy, 0);
    chk(beats, (en && nb == 3) ? 256 : 0);
    chk(clears, en || nb < 3);
  endtask

  initial begin
    write_enable_latch = 1'b0;
    pready = 1'b0;
    qaddr = 24'h00_0000;
    repeat (16) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    chk_wrap();
    for (int k = 0; k < 4; k++) begin
      w = 8'(rnd());
      w[6:4] = {2'(k), 1'b0};
      set_wrap(w, 16);
      chk_wrap();
    end
    // Reset in mid-run must drop an enabled wrap setting
    rstn_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    rstn_i = 1'b1;
    wcfg = 3'h1;
    chk_wrap();
    set_wrap(w, 16);
    chk_wrap();
    set_wrap(w ^ 8'h70, 17);
    chk_wrap();
    set_wrap(8'(rnd()) | 8'h10, 24);
    chk_wrap();
    write_enable_latch = 1'b1;
    bwrite(8'h00, 256, 0);
    bwrite(8'hFA, 10, 0);
    bwrite(8'h02, 2, 3);
    write_enable_latch = 1'b0;
    bwrite(8'hFC, 2, 0);
    bread(8'hFC, 8);
    bprog(24'(rnd()), 1'b1, 3);
    bprog(24'(rnd()), 1'b0, 3);
    bprog(24'(rnd()), 1'b1, 2);
    final_report();
  end

  initial begin
    #1_000_000;
    err_total++;
    final_report();
  end
endmodule
